// *** verilog/mqrps_read_port.sv ***
// Read-port queue and status word selection of a multi-queue buffer
//
// Operation
// - Read enable edge outputs next queue word
// - Strobed status select picks direct status word
// - Polled mode steps status bus, sync marks start
// - Flag outputs registered on the read clock
// - Expansion pins timed on the read clock
// - Chip select and enables gate bus drive
// - Chip select ignored during master reset
// - Low five address bits pick queue
// - Upper three bits must match device id
// - Selection edge may still output old word
// - New queue word appears two edges later
// - Status selection uses low four bits only
// - Status strobe edge captures status address
// - Fall-through selection independent of read enable
// - Status bus needs no read enable
// - Data driven only with output enable, selection
`timescale 1ns/1ps
`default_nettype none
module mqrps_read_port #(
    parameter int DATA_W = mqrps_pkg::DATA_W,
    parameter int NUM_Q  = mqrps_pkg::NUM_Q
) (
    input  wire logic                                             mclk,
    input  wire logic                                             rst,
    input  wire logic                                             fallThroughMode,
    input  wire logic                                             polledFlagMode,
    input  wire logic                                             mrstActive,
    input  wire logic [mqrps_pkg::DEV_W-1:0]                      deviceId,
    input  wire logic                                             rdEnN,
    input  wire logic                                             rdChipSelN,
    input  wire logic                                             outEnN,
    input  wire logic [mqrps_pkg::ADDR_W-1:0]                     rdAddrBus,
    input  wire logic                                             rdAddrStrobe,
    input  wire logic                                             statusSelStrobe,
    input  wire logic                                             srcValid,
    input  wire logic [DATA_W-1:0]                                srcData,
    output logic                                                  srcReady,
    output logic [mqrps_pkg::QIDX_W-1:0]                          srcQueue,
    input  wire logic [NUM_Q-1:0]                                 qAlmostEmpty,
    input  wire logic [NUM_Q-1:0]                                 qPacketReady,
    input  wire logic [mqrps_pkg::NUM_STAT*mqrps_pkg::STAT_W-1:0] aeStatusWords,
    input  wire logic [mqrps_pkg::NUM_STAT*mqrps_pkg::STAT_W-1:0] prStatusWords,
    input  wire logic                                             expansionIn,
    output logic [DATA_W-1:0]                                     dataOut,
    output logic                                                  dataDriveN,
    output logic                                                  outputReadyFlag,
    output logic                                                  almostEmptyFlag,
    output logic                                                  packetReadyFlag,
    output logic [mqrps_pkg::STAT_W-1:0]                          queueAlmostEmptyBus,
    output logic [mqrps_pkg::STAT_W-1:0]                          packetReadyBus,
    output logic                                                  statusSync,
    output logic                                                  expansionOut
);
    import mqrps_pkg::*;

    mqrps_sel_state_t        selState_q;
    mqrps_sel_state_t        selState_d;
    logic [QIDX_W-1:0]       selQ_q;
    logic                    qSelected_q;
    logic [STAT_IDX_W-1:0]   statIdx_q;
    logic [DATA_W-1:0]       dataOut_q;
    logic                    outValid_q;
    logic                    dataDriveN_q;
    logic                    almostEmpty_q;
    logic                    packetReady_q;
    logic [STAT_W-1:0]       aeBus_q;
    logic [STAT_W-1:0]       prBus_q;
    logic                    statusSync_q;
    logic                    expOut_q;
    logic                    expIn_q;
    logic                    devMatch;
    logic                    selCapture;
    logic                    statCapture;
    logic                    readAllowed;
    logic                    forceLoad;
    logic                    outPop;
    logic                    bufValid;
    logic [DATA_W-1:0]       bufData;

    function automatic logic [STAT_W-1:0] pickWord(
        input logic [NUM_STAT*STAT_W-1:0] words,
        input logic [STAT_IDX_W-1:0]      idx
    );
        return words[idx*STAT_W +: STAT_W];
    endfunction

    // Strobe decode; the address strobe wins if both arrive
    assign devMatch    = (rdAddrBus[DEV_LSB +: DEV_W] == deviceId);
    assign selCapture  = rdAddrStrobe && !mrstActive;
    assign statCapture = statusSelStrobe && !rdAddrStrobe && !mrstActive
                         && !polledFlagMode && devMatch;

    // Read and fall-through loading of the output register
    assign readAllowed = !rdEnN && !rdChipSelN && !mrstActive && qSelected_q;
    assign forceLoad   = fallThroughMode && !mrstActive && qSelected_q
                         && ((selState_q == SEL_WAIT2) || !outValid_q);
    assign outPop      = bufValid && (readAllowed || forceLoad);

    mqrps_skid_buf #(
        .W     (DATA_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk      (mclk),
        .rst      (rst),
        .flush    (selCapture),
        .inValid  (srcValid),
        .inData   (srcData),
        .inReady  (srcReady),
        .outValid (bufValid),
        .outData  (bufData),
        .outReady (outPop)
    );

    // Queue selection holds until the next strobed edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            selQ_q      <= QIDX_RST;
            qSelected_q <= 1'b0;
        end else if (selCapture) begin
            selQ_q      <= rdAddrBus[QIDX_LSB +: QIDX_W];
            qSelected_q <= devMatch;
        end
    end

    always_comb begin
        case (selState_q)
            SEL_IDLE:  selState_d = SEL_IDLE;
            SEL_WAIT1: selState_d = SEL_WAIT2;
            SEL_WAIT2: selState_d = SEL_IDLE;
            default:   selState_d = SEL_IDLE;
        endcase
        if (selCapture && devMatch) begin
            selState_d = SEL_WAIT1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            selState_q <= SEL_IDLE;
        end else begin
            selState_q <= selState_d;
        end
    end

    // Output register; the old queue may still be read on the select edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dataOut_q  <= DATA_RST;
            outValid_q <= 1'b0;
        end else if (outPop) begin
            dataOut_q  <= bufData;
            outValid_q <= 1'b1;
        end else if (readAllowed) begin
            outValid_q <= 1'b0;
        end
    end

    // Bus drive enable, low while driving
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dataDriveN_q <= 1'b1;
        end else begin
            dataDriveN_q <= outEnN || rdChipSelN || mrstActive || !qSelected_q;
        end
    end

    // Flags of the selected queue
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            almostEmpty_q <= 1'b0;
            packetReady_q <= 1'b0;
        end else begin
            almostEmpty_q <= qAlmostEmpty[selQ_q];
            packetReady_q <= qPacketReady[selQ_q];
        end
    end

    // Status word index: direct capture or polled stepping, no read enable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            statIdx_q <= STAT_RST;
        end else if (polledFlagMode) begin
            if (expIn_q) begin
                statIdx_q <= statIdx_q + 1'b1;
            end
        end else if (statCapture) begin
            statIdx_q <= rdAddrBus[STAT_LSB +: STAT_IDX_W];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aeBus_q      <= WORD_RST;
            prBus_q      <= WORD_RST;
            statusSync_q <= 1'b0;
        end else begin
            aeBus_q      <= pickWord(aeStatusWords, statIdx_q);
            prBus_q      <= pickWord(prStatusWords, statIdx_q);
            statusSync_q <= polledFlagMode && (statIdx_q == STAT_RST);
        end
    end

    // Expansion: token in enables polling, token out on the last word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            expIn_q  <= 1'b0;
            expOut_q <= 1'b0;
        end else begin
            expIn_q  <= expansionIn;
            expOut_q <= polledFlagMode && expIn_q && (statIdx_q == STAT_LAST);
        end
    end

    assign srcQueue            = selQ_q;
    assign dataOut             = dataOut_q;
    assign dataDriveN          = dataDriveN_q;
    assign outputReadyFlag     = outValid_q;
    assign almostEmptyFlag     = almostEmpty_q;
    assign packetReadyFlag     = packetReady_q;
    assign queueAlmostEmptyBus = aeBus_q;
    assign packetReadyBus      = prBus_q;
    assign statusSync          = statusSync_q;
    assign expansionOut        = expOut_q;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_newSel;
        selCapture && devMatch && fallThroughMode;
    endsequence

    sequence s_firstWord;
        srcValid && srcReady && !selCapture && !mrstActive;
    endsequence

    a_sel_capture: assert property (selCapture |=>
        (selQ_q == $past(rdAddrBus[QIDX_LSB +: QIDX_W])))
        else $error("queue selection not captured");

    a_sel_hold: assert property (!selCapture |=> $stable(selQ_q))
        else $error("queue selection changed without strobe");

    a_dev_match: assert property (selCapture && !devMatch |=> !qSelected_q)
        else $error("foreign device address selected this device");

    a_stat_capture: assert property (statCapture |=>
        (statIdx_q == $past(rdAddrBus[STAT_LSB +: STAT_IDX_W])) ##1
        (aeBus_q == pickWord($past(aeStatusWords), $past(statIdx_q))))
        else $error("status word selection wrong");

    a_poll_step: assert property (polledFlagMode && expIn_q |=>
        (statIdx_q == $past(statIdx_q) + 1'b1))
        else $error("polled status index did not step");

    a_sync_start: assert property (statusSync |->
        ($past(statIdx_q) == STAT_RST) && $past(polledFlagMode))
        else $error("status sync off the first word");

    a_read_word: assert property (readAllowed && bufValid |=>
        outValid_q && (dataOut == $past(bufData)))
        else $error("read did not present next word");

    a_fall_through_mode_delay: assert property (s_newSel ##1 s_firstWord |=>
        ##1 (outValid_q && (dataOut == $past(srcData, 2))))
        else $error("new queue word not out two edges after select");

    a_drive_gate: assert property (!dataDriveN |->
        $past(!outEnN && !rdChipSelN && !mrstActive && qSelected_q))
        else $error("bus driven without enables");

    a_reset_hold: assert property (mrstActive && !forceLoad |=> $stable(dataOut))
        else $error("output changed during master reset");

    a_flag_track: assert property (1'b1 |=>
        (almostEmptyFlag == $past(qAlmostEmpty[selQ_q])))
        else $error("almost empty flag does not follow queue");

endmodule
`default_nettype wire

// *** verilog/mqrps_pkg.sv ***
// Shared constants and types of the multi-queue read-port select block
package mqrps_pkg;

    // Data and address widths
    localparam int DATA_W        = 36;
    localparam int ADDR_W        = 8;
    localparam int NUM_Q         = 32;
    localparam int BUF_DEPTH     = 2;

    // Read address bus field layout
    localparam int QIDX_LSB      = 0;
    localparam int QIDX_W        = 5;
    localparam int DEV_LSB       = 5;
    localparam int DEV_W         = 3;
    localparam int STAT_LSB      = 0;
    localparam int STAT_IDX_W    = 4;

    // Status word bus
    localparam int NUM_STAT      = 16;
    localparam int STAT_W        = 8;

    // Read clock
    localparam int CLK_PERIOD_NS = 40;

    // Reset values
    localparam logic [QIDX_W-1:0]     QIDX_RST  = 5'h00;
    localparam logic [STAT_IDX_W-1:0] STAT_RST  = 4'h0;
    localparam logic [STAT_IDX_W-1:0] STAT_LAST = 4'hf;
    localparam logic [DATA_W-1:0]     DATA_RST  = 36'h000000000;
    localparam logic [STAT_W-1:0]     WORD_RST  = 8'h00;

    // Queue change sequence, Gray coded
    typedef enum logic [1:0] {
        SEL_IDLE  = 2'b00,
        SEL_WAIT1 = 2'b01,
        SEL_WAIT2 = 2'b11
    } mqrps_sel_state_t;

endpackage

// *** verilog/mqrps_skid_buf.sv ***
// Two-entry valid/ready buffer between queue memory and the output register
`timescale 1ns/1ps
`default_nettype none
module mqrps_skid_buf #(
    parameter int W     = mqrps_pkg::DATA_W,
    parameter int DEPTH = mqrps_pkg::BUF_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         flush,
    input  wire logic         inValid,
    input  wire logic [W-1:0] inData,
    output logic              inReady,
    output logic              outValid,
    output logic [W-1:0]      outData,
    input  wire logic         outReady
);
    import mqrps_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] rdPtr_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          inReady_q;
    logic          push;
    logic          pop;

    function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // A flush drops stale words of the previous queue
    assign push     = inValid && inReady_q && !flush;
    assign pop      = outValid && outReady && !flush;
    assign inReady  = inReady_q;
    assign outValid = (cnt_q != '0);
    assign outData  = mem[rdPtr_q];

    always_comb begin
        if (flush) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q     <= '0;
            inReady_q <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            inReady_q <= (cnt_d != CW'(DEPTH));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else if (flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= nextPtr(wrPtr_q);
            end
            if (pop) begin
                rdPtr_q <= nextPtr(rdPtr_q);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

endmodule
`default_nettype wire

// *** sim/mqrps_src_model.sv ***
// Queue memory model that offers numbered words of the selected queue
`timescale 1ns/1ps
`default_nettype none
module mqrps_src_model (
    input  wire logic                           mclk,
    input  wire logic                           rst,
    input  wire logic                           stall,
    input  wire logic [mqrps_pkg::QIDX_W-1:0]   srcQueue,
    input  wire logic                           srcReady,
    output logic                                srcValid,
    output logic [mqrps_pkg::DATA_W-1:0]        srcData
);
    import mqrps_pkg::*;

    logic [DATA_W-QIDX_W-1:0] cnt [NUM_Q];
    logic [DATA_W-1:0]        word;

    assign word     = {srcQueue, cnt[srcQueue]};
    assign srcValid = !stall;
    // A stalled source shows no stale word
    assign srcData  = stall ? ~word : word;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_Q; i++) begin
                cnt[i] <= 31'(i * 16);
            end
        end else if (srcValid && srcReady) begin
            cnt[srcQueue] <= cnt[srcQueue] + 31'h1;
        end
    end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking testbench of the read-port select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mqrps_pkg::*;

    localparam logic [DEV_W-1:0] DEV_ID  = 3'h5;
    localparam int               TIMEOUT = 5000;

    logic                        mclk, rst, fallThroughMode, polledFlagMode, mrstActive;
    logic                        rdEnN, rdChipSelN, outEnN, rdAddrStrobe, statusSelStrobe;
    logic                        srcValid, srcReady, expansionIn, stall;
    logic                        dataDriveN, outputReadyFlag, almostEmptyFlag, packetReadyFlag;
    logic                        statusSync, expansionOut;
    logic [DEV_W-1:0]            deviceId;
    logic [ADDR_W-1:0]           rdAddrBus;
    logic [QIDX_W-1:0]           srcQueue, curQ;
    logic [DATA_W-1:0]           srcData, dataOut;
    logic [NUM_Q-1:0]            qAlmostEmpty, qPacketReady;
    logic [NUM_STAT*STAT_W-1:0]  aeStatusWords, prStatusWords;
    logic [STAT_W-1:0]           queueAlmostEmptyBus, packetReadyBus;
    logic [DATA_W-QIDX_W-1:0]    curSeq;
    int                          errors, cmpCount, cycles;

    mqrps_read_port dut (
        .mclk, .rst, .fallThroughMode, .polledFlagMode, .mrstActive, .deviceId, .rdEnN,
        .rdChipSelN, .outEnN, .rdAddrBus, .rdAddrStrobe, .statusSelStrobe, .srcValid,
        .srcData, .srcReady, .srcQueue, .qAlmostEmpty, .qPacketReady, .aeStatusWords,
        .prStatusWords, .expansionIn, .dataOut, .dataDriveN, .outputReadyFlag,
        .almostEmptyFlag, .packetReadyFlag, .queueAlmostEmptyBus, .packetReadyBus,
        .statusSync, .expansionOut
    );

    mqrps_src_model src (
        .mclk, .rst, .stall, .srcQueue, .srcReady, .srcValid, .srcData
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                            input string what);
        cmpCount++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bus(input logic [STAT_W-1:0] got, input logic [STAT_W-1:0] exp,
                           input string what);
        cmp_word(DATA_W'(got), DATA_W'(exp), what);
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_word(DATA_W'(got), DATA_W'(exp), what);
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, errors %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == TIMEOUT) begin
            errors++;
            $display("Error at %0t: timeout", $time);
            end_of_test();
        end
    end

    task automatic wait_for(ref logic s, input int lim);
        int k = 0;
        while (s !== 1'b1 && k < lim) begin
            @(posedge mclk);
            #1;
            k++;
        end
    endtask

    // One-cycle strobe, the status strobe stays low
    task automatic select_queue(input logic [QIDX_W-1:0] q, input logic [DEV_W-1:0] dev);
        @(posedge mclk);
        rdAddrStrobe <= 1'b1;
        rdAddrBus <= {dev, q};
        @(posedge mclk);
        rdAddrStrobe <= 1'b0;
        #1;
    endtask

    task automatic read_one;
        @(posedge mclk);
        rdEnN <= 1'b0;
        @(posedge mclk);
        rdEnN <= 1'b1;
        #1;
    endtask

    task automatic t_reset;
        cmp_bit(dataDriveN, 1'b1, "drive after reset");
        read_one();
        read_one();
        cmp_bit(outputReadyFlag, 1'b0, "read with no queue");
        cmp_bit(dataDriveN, 1'b1, "drive with no queue");
    endtask

    // Read enable stays high: the first word must fall through anyway
    task automatic t_select(input logic [QIDX_W-1:0] q);
        select_queue(q, DEV_ID);
        cmp_bus(8'(srcQueue), 8'(q), "queue index");
        curQ = q;
        curSeq = src.cnt[q];
        repeat (2) @(posedge mclk);
        #1;
        cmp_word(dataOut, {curQ, curSeq}, "first word");
        cmp_bit(outputReadyFlag, 1'b1, "ready without read");
        cmp_bit(almostEmptyFlag, qAlmostEmpty[q], "almost empty flag");
        cmp_bit(packetReadyFlag, qPacketReady[q], "packet ready flag");
        cmp_bit(dataDriveN, 1'b0, "drive when selected");
    endtask

    task automatic t_burst(input int n);
        @(posedge mclk);
        rdEnN <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            if (i == n - 1) rdEnN <= 1'b1;
            #1;
            curSeq++;
            cmp_word(dataOut, {curQ, curSeq}, "back to back read");
        end
    endtask

    // Drain with the source stalled, then check that no word went missing
    task automatic t_stall;
        int k;
        @(posedge mclk);
        stall <= 1'b1;
        k = 0;
        while (outputReadyFlag === 1'b1 && k < 6) begin
            read_one();
            k++;
            if (outputReadyFlag === 1'b1) begin
                curSeq++;
                cmp_word(dataOut, {curQ, curSeq}, "read under stall");
            end
        end
        cmp_bit(outputReadyFlag, 1'b0, "empty under stall");
        cmp_bit(srcReady, 1'b1, "source ready when drained");
        @(posedge mclk);
        stall <= 1'b0;
        #1;
        wait_for(outputReadyFlag, 10);
        curSeq++;
        cmp_word(dataOut, {curQ, curSeq}, "word after stall");
    endtask

    task automatic t_gate;
        logic [2:0] g;
        for (int i = 0; i < 8; i++) begin
            g = 3'(i);
            @(posedge mclk);
            rdChipSelN <= g[0];
            outEnN <= g[1];
            mrstActive <= g[2];
            @(posedge mclk);
            #1;
            cmp_bit(dataDriveN, |g, "drive gating");
        end
        @(posedge mclk);
        rdChipSelN <= 1'b0;
        outEnN <= 1'b0;
        mrstActive <= 1'b0;
        @(posedge mclk);
        #1;
        cmp_bit(dataDriveN, 1'b0, "drive restored");
    endtask

    task automatic t_other_device;
        select_queue(5'h03, DEV_ID + 3'h1);
        @(posedge mclk);
        #1;
        cmp_bit(dataDriveN, 1'b1, "other device addressed");
    endtask

    // Bit 4 toggles between words and must not matter
    task automatic t_status;
        for (int i = 0; i < NUM_STAT; i++) begin
            @(posedge mclk);
            statusSelStrobe <= 1'b1;
            rdAddrBus <= {DEV_ID, 1'(i % 2), 4'(i)};
            @(posedge mclk);
            statusSelStrobe <= 1'b0;
            @(posedge mclk);
            #1;
            cmp_bus(queueAlmostEmptyBus, aeStatusWords[i*STAT_W+:STAT_W], "ae word");
            cmp_bus(packetReadyBus, prStatusWords[i*STAT_W+:STAT_W], "pr word");
        end
        repeat (3) @(posedge mclk);
        #1;
        cmp_bus(queueAlmostEmptyBus, aeStatusWords[15*STAT_W+:STAT_W], "word held");
    endtask

    task automatic t_polled;
        @(posedge mclk);
        polledFlagMode <= 1'b1;
        expansionIn <= 1'b1;
        #1;
        wait_for(statusSync, 40);
        cmp_bit(statusSync, 1'b1, "polled sync");
        cmp_bus(queueAlmostEmptyBus, aeStatusWords[0+:STAT_W], "polled word 0");
        @(posedge mclk);
        #1;
        cmp_bus(queueAlmostEmptyBus, aeStatusWords[STAT_W+:STAT_W], "polled word 1");
        cmp_bit(statusSync, 1'b0, "sync one word");
        wait_for(expansionOut, 20);
        cmp_bit(expansionOut, 1'b1, "token out");
    endtask

    initial begin
        {rst, fallThroughMode, rdEnN, rdChipSelN, outEnN} = 5'h1f;
        {polledFlagMode, mrstActive, rdAddrStrobe, statusSelStrobe, stall} = 5'h00;
        {expansionIn, rdAddrBus, deviceId, errors, cmpCount, cycles} = '0;
        {rdChipSelN, outEnN, deviceId} = {2'b00, DEV_ID};
        qAlmostEmpty = 32'h00000080;
        qPacketReady = 32'h00100000;
        for (int i = 0; i < NUM_STAT; i++) begin
            aeStatusWords[i*STAT_W+:STAT_W] = 8'(8'h30 + i);
            prStatusWords[i*STAT_W+:STAT_W] = 8'(8'hc0 ^ i);
        end
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_select(5'h07);
        t_burst(5);
        t_stall();
        t_select(5'h14);
        t_burst(3);
        t_gate();
        t_other_device();
        t_status();
        t_polled();
        end_of_test();
    end
endmodule
`default_nettype wire
